// >>> core/fbp_pkg.sv
// Purpose: shared constants and types of the flash bus port
// Assumes: 16-bit data bus, four planes, word addressing
// Notes: apb offsets are byte addresses of 32-bit words
package fbp_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RCR = 8'h00;
  localparam logic [7:0] REG_PART = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_PSTAT = 8'h0C;
  // ---------------------------------------------------------------
  // read_config_reg fields
  // ---------------------------------------------------------------
  localparam int RCR_ASYNC = 15;
  localparam int RCR_LAT_LSB = 11;
  localparam int RCR_EDGE = 6;
  localparam int RCR_NOWRAP = 3;
  localparam int RCR_LEN_LSB = 0;
  localparam logic [15:0] RCR_RESET = 16'h8040;
  localparam logic [2:0] LEN_4 = 3'h1;
  localparam logic [2:0] LEN_8 = 3'h2;
  localparam logic [2:0] PART_RESET = 3'h0;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
  localparam logic [7:0] CMD_PART_CFG = 8'h04;
  // ---------------------------------------------------------------
  // status byte and error vector
  // ---------------------------------------------------------------
  localparam int ST_READY = 7;
  localparam int ST_ERASE = 5;
  localparam int ST_PROG = 4;
  localparam int ST_VPP = 3;
  localparam int ST_LOCK = 1;
  localparam int ERR_ERASE = 3;
  localparam int ERR_PROG = 2;
  localparam int ERR_VPP = 1;
  localparam int ERR_LOCK = 0;
  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int MAIN_LSB = 15;
  localparam int PARAM_LSB = 12;
  localparam int PARAM_BLOCKS = 8;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic flash_clk;
    logic adv_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
    logic wp_n;
    logic vpp_low;
  } fbp_pins_type;
  localparam fbp_pins_type PINS_IDLE = 8'h7B;
  typedef enum logic [1:0] {
    CS_IDLE, CS_PROG, CS_ERASE, CS_LOCK
  } fbp_cmd_state_type;
endpackage

// >>> core/fbp_flash_port.sv
// Purpose: bus port, command front end and protection of a flash
// Assumes: pins are slow against pclk; array answers in one cycle
// Notes: all pins pass two flip-flops before use
`timescale 1ns/100ps
module fbp_flash_port #(
  parameter int ADDR_W = 21,
  parameter int DQ_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins
  input wire logic flash_clk,
  input wire logic address_latch_strobe_n,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic hard_init_n,
  input wire logic lockdown_guard_n,
  input wire logic vpp_at_lockout,
  input wire logic [ADDR_W-1:0] addr_pin,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic burst_data_valid,
  // array and program/erase engine
  output logic [ADDR_W-1:0] array_addr,
  input wire logic [DQ_W-1:0] array_rdata,
  output logic pe_start,
  output logic pe_is_erase,
  output logic [ADDR_W-1:0] pe_addr,
  output logic [DQ_W-1:0] pe_data,
  output logic pe_abort,
  input wire logic pe_done
);
  localparam int SLOT_W = ADDR_W - fbp_pkg::MAIN_LSB;
  localparam int NBLK = 2**SLOT_W + fbp_pkg::PARAM_BLOCKS - 1;
  localparam int BLK_W = $clog2(NBLK);

  if (ADDR_W < 21 || ADDR_W > 22 || DQ_W != 16) begin : g_chk
    $error("fbp_flash_port: ADDR_W must be 21 or 22, DQ_W 16");
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // top slot of the top plane is split into small parameter blocks
  function automatic logic [BLK_W-1:0] block_of(
    input logic [ADDR_W-1:0] a);
    logic [SLOT_W-1:0] s;
    s = a[ADDR_W-1:fbp_pkg::MAIN_LSB];
    if (&s) begin
      block_of = BLK_W'(s) + BLK_W'(a[14:fbp_pkg::PARAM_LSB]);
    end else begin
      block_of = BLK_W'(s);
    end
  endfunction

  // cfg bit i places a boundary between plane i and plane i+1
  function automatic logic [1:0] part_of(input logic [2:0] cfg,
    input logic [ADDR_W-1:0] a);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 0; i < 3; i++) begin
      if (i < int'(a[ADDR_W-1 -: 2]) && cfg[i]) begin
        n = n + 2'h1;
      end
    end
    part_of = n;
  endfunction

  function automatic logic [7:0] stat_of(input logic [3:0] e,
    input logic rdy);
    logic [7:0] s;
    s = 8'h00;
    s[fbp_pkg::ST_READY] = rdy;
    s[fbp_pkg::ST_ERASE] = e[fbp_pkg::ERR_ERASE];
    s[fbp_pkg::ST_PROG] = e[fbp_pkg::ERR_PROG];
    s[fbp_pkg::ST_VPP] = e[fbp_pkg::ERR_VPP];
    s[fbp_pkg::ST_LOCK] = e[fbp_pkg::ERR_LOCK];
    stat_of = s;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // buses ride with the strobes; they are only used once a strobe
  // edge has settled, so skew between bits does not matter
  fbp_pkg::fbp_pins_type p_in, p_m_r, p_s_r, p_d_r;
  logic [ADDR_W-1:0] a_m_r, a_s_r;
  logic [DQ_W-1:0] d_m_r, d_s_r;

  assign p_in = '{flash_clk, address_latch_strobe_n, chip_select_n,
    write_strobe_n, output_gate_n, hard_init_n, lockdown_guard_n,
    vpp_at_lockout};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_m_r <= fbp_pkg::PINS_IDLE;
      p_s_r <= fbp_pkg::PINS_IDLE;
      p_d_r <= fbp_pkg::PINS_IDLE;
      a_m_r <= '0;
      a_s_r <= '0;
      d_m_r <= '0;
      d_s_r <= '0;
    end else begin
      p_m_r <= p_in;
      p_s_r <= p_m_r;
      p_d_r <= p_s_r;
      a_m_r <= addr_pin;
      a_s_r <= a_m_r;
      d_m_r <= dq_in;
      d_s_r <= d_m_r;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] rcr_r;
  logic [2:0] part_r, part_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt, wa_r, baddr_r, baddr_nxt;
  logic [DQ_W-1:0] wd_r;
  logic taken_r, taken_nxt, bst_r, bst_nxt, busy_r;
  logic [2:0] lat_r, lat_nxt;
  logic [1:0] bpart_r;
  fbp_pkg::fbp_cmd_state_type cs_r, cs_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic [3:0][3:0] err_r, err_nxt;
  logic [NBLK-1:0] lock_r, lock_nxt, ldn_r, ldn_nxt;
  logic go, go_erase;

  // ---------------------------------------------------------------
  // edges and address latch
  // ---------------------------------------------------------------
  wire rst_s = p_s_r.rst_n;
  wire sync_mode = ~rcr_r[fbp_pkg::RCR_ASYNC];
  wire clk_rise = p_s_r.flash_clk & ~p_d_r.flash_clk;
  wire clk_fall = ~p_s_r.flash_clk & p_d_r.flash_clk;
  wire clk_edge = rcr_r[fbp_pkg::RCR_EDGE] ? clk_rise : clk_fall;
  wire adv_low = ~p_s_r.adv_n;
  wire adv_rise = p_s_r.adv_n & ~p_d_r.adv_n;
  wire wr_now = ~p_s_r.ce_n & ~p_s_r.we_n;
  wire wr_end = ~p_d_r.ce_n & ~p_d_r.we_n & ~wr_now;
  wire [ADDR_W-1:0] cur_addr = adv_low ? a_s_r : addr_r;
  wire bst_cap = sync_mode & ~taken_r &
    ((adv_low & clk_edge) | adv_rise);

  assign addr_nxt = (adv_low & ~taken_r) ? a_s_r : addr_r;
  assign taken_nxt = p_s_r.adv_n ? 1'b0 : (taken_r | bst_cap);

  // ---------------------------------------------------------------
  // burst sequencing
  // ---------------------------------------------------------------
  wire [2:0] lat_val = rcr_r[fbp_pkg::RCR_LAT_LSB +: 3];
  wire [2:0] blen = rcr_r[fbp_pkg::RCR_LEN_LSB +: 3];
  wire nowrap = rcr_r[fbp_pkg::RCR_NOWRAP];
  wire [ADDR_W-1:0] binc = baddr_r + 1'b1;
  wire bstep = bst_r & clk_edge & (lat_r == 3'h0);
  wire [ADDR_W-1:0] bwrap =
    (~nowrap & blen == fbp_pkg::LEN_4) ? {baddr_r[ADDR_W-1:2], binc[1:0]} :
    (~nowrap & blen == fbp_pkg::LEN_8) ? {baddr_r[ADDR_W-1:3], binc[2:0]} :
    binc;

  assign bst_nxt = (p_s_r.ce_n | ~sync_mode) ? 1'b0 : (bst_r | bst_cap);
  assign baddr_nxt = bst_cap ? cur_addr : (bstep ? bwrap : baddr_r);
  assign lat_nxt = bst_cap ? lat_val :
    (bst_r & clk_edge & lat_r != 3'h0) ? 3'(lat_r - 3'h1) : lat_r;
  // flag idles high like the pulled-up pin; low only in latency
  wire bdv_nxt = ~(sync_mode & bst_r & ~p_s_r.oe_n &
    (lat_r != 3'h0));

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [3:0][7:0] st_byte;
  for (genvar g = 0; g < 4; g++) begin : g_st
    assign st_byte[g] = stat_of(err_r[g],
      ~(busy_r && bpart_r == 2'(g)));
  end

  wire [ADDR_W-1:0] rd_addr = bst_r ? baddr_r : addr_r;
  wire [1:0] rd_part = part_of(part_r, rd_addr);
  wire rd_cycle = ~p_s_r.ce_n & ~p_s_r.oe_n & p_s_r.we_n;
  // the busy partition can only answer with status
  wire show_st = mode_r[rd_part] |
    (busy_r & bpart_r == rd_part);
  wire [DQ_W-1:0] dq_nxt = show_st ?
    DQ_W'(st_byte[rd_part]) : array_rdata;

  // ---------------------------------------------------------------
  // command front end
  // ---------------------------------------------------------------
  wire [7:0] cmd = wd_r[7:0];
  wire [1:0] wp = part_of(part_r, wa_r);
  wire [BLK_W-1:0] wblk = block_of(wa_r);

  always_comb begin
    logic op_try;
    int eb;
    op_try = 1'b0;
    eb = fbp_pkg::ERR_PROG;
    cs_nxt = cs_r;
    mode_nxt = mode_r;
    err_nxt = err_r;
    lock_nxt = lock_r;
    ldn_nxt = ldn_r;
    part_nxt = part_r;
    go = 1'b0;
    go_erase = 1'b0;
    if (wr_end) begin
      unique case (cs_r)
        fbp_pkg::CS_IDLE: begin
          if (cmd == fbp_pkg::CMD_READ_ARRAY) begin
            mode_nxt[wp] = 1'b0;
          end else if (cmd == fbp_pkg::CMD_READ_STATUS) begin
            mode_nxt[wp] = 1'b1;
          end else if (cmd == fbp_pkg::CMD_CLEAR_STATUS) begin
            err_nxt[wp] = 4'h0;
          end else if (cmd == fbp_pkg::CMD_PROGRAM) begin
            cs_nxt = fbp_pkg::CS_PROG;
            mode_nxt[wp] = 1'b1;
          end else if (cmd == fbp_pkg::CMD_ERASE) begin
            cs_nxt = fbp_pkg::CS_ERASE;
            mode_nxt[wp] = 1'b1;
          end else if (cmd == fbp_pkg::CMD_LOCK_SETUP) begin
            cs_nxt = fbp_pkg::CS_LOCK;
          end
        end
        fbp_pkg::CS_PROG: begin
          cs_nxt = fbp_pkg::CS_IDLE;
          op_try = 1'b1;
        end
        fbp_pkg::CS_ERASE: begin
          cs_nxt = fbp_pkg::CS_IDLE;
          eb = fbp_pkg::ERR_ERASE;
          if (cmd == fbp_pkg::CMD_CONFIRM) begin
            op_try = 1'b1;
          end else begin
            err_nxt[wp][fbp_pkg::ERR_ERASE] = 1'b1;
            err_nxt[wp][fbp_pkg::ERR_PROG] = 1'b1;
          end
        end
        fbp_pkg::CS_LOCK: begin
          cs_nxt = fbp_pkg::CS_IDLE;
          if (cmd == fbp_pkg::CMD_LOCK) begin
            lock_nxt[wblk] = 1'b1;
          end else if (cmd == fbp_pkg::CMD_CONFIRM) begin
            if (ldn_r[wblk] & ~p_s_r.wp_n) begin
              err_nxt[wp][fbp_pkg::ERR_LOCK] = 1'b1;
            end else begin
              lock_nxt[wblk] = 1'b0;
            end
          end else if (cmd == fbp_pkg::CMD_LOCKDOWN) begin
            lock_nxt[wblk] = 1'b1;
            ldn_nxt[wblk] = 1'b1;
          end else if (cmd == fbp_pkg::CMD_PART_CFG && !busy_r) begin
            part_nxt = wa_r[2:0];
          end else begin
            err_nxt[wp][fbp_pkg::ERR_ERASE] = 1'b1;
            err_nxt[wp][fbp_pkg::ERR_PROG] = 1'b1;
          end
        end
      endcase
      if (op_try) begin
        if (busy_r) begin
          err_nxt[wp][eb] = 1'b1;
        end else if (p_s_r.vpp_low) begin
          err_nxt[wp][eb] = 1'b1;
          err_nxt[wp][fbp_pkg::ERR_VPP] = 1'b1;
        end else if (lock_r[wblk]) begin
          err_nxt[wp][eb] = 1'b1;
          err_nxt[wp][fbp_pkg::ERR_LOCK] = 1'b1;
        end else begin
          go = 1'b1;
          go_erase = (eb == fbp_pkg::ERR_ERASE);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  wire hit_rcr = paddr == fbp_pkg::REG_RCR;
  wire hit_part = paddr == fbp_pkg::REG_PART;
  wire hit_stat = paddr == fbp_pkg::REG_STAT;
  wire hit_pstat = paddr == fbp_pkg::REG_PSTAT;
  wire mapped = hit_rcr | hit_part | hit_stat | hit_pstat;
  wire [31:0] stat_word = {24'h000000, bst_r, sync_mode,
    p_s_r.vpp_low, p_s_r.wp_n, rst_s, bpart_r, busy_r};
  wire [31:0] rd_word = hit_rcr ? {16'h0000, rcr_r} :
    hit_part ? {29'h0, part_r} :
    hit_stat ? stat_word :
    hit_pstat ? st_byte : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~mapped;
      prdata <= (apb_setup & ~pwrite) ? rd_word : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // init low returns everything to asynchronous array read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcr_r <= fbp_pkg::RCR_RESET;
      part_r <= fbp_pkg::PART_RESET;
      cs_r <= fbp_pkg::CS_IDLE;
      mode_r <= 4'h0;
      err_r <= '0;
      lock_r <= '1;
      ldn_r <= '0;
    end else if (!rst_s) begin
      rcr_r <= fbp_pkg::RCR_RESET;
      part_r <= fbp_pkg::PART_RESET;
      cs_r <= fbp_pkg::CS_IDLE;
      mode_r <= 4'h0;
      err_r <= '0;
      lock_r <= '1;
      ldn_r <= '0;
    end else begin
      rcr_r <= (apb_wr & hit_rcr) ? pwdata[15:0] : rcr_r;
      part_r <= (apb_wr & hit_part & ~busy_r) ? pwdata[2:0] : part_nxt;
      cs_r <= cs_nxt;
      mode_r <= mode_nxt;
      err_r <= err_nxt;
      lock_r <= lock_nxt;
      ldn_r <= ldn_nxt;
    end
  end

  // ---------------------------------------------------------------
  // bus capture, burst and engine
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= '0;
      taken_r <= 1'b0;
      wa_r <= '0;
      wd_r <= '0;
      bst_r <= 1'b0;
      baddr_r <= '0;
      lat_r <= 3'h0;
      burst_data_valid <= 1'b1;
    end else begin
      addr_r <= addr_nxt;
      taken_r <= taken_nxt;
      wa_r <= wr_now ? cur_addr : wa_r;
      wd_r <= wr_now ? d_s_r : wd_r;
      bst_r <= bst_nxt;
      baddr_r <= baddr_nxt;
      lat_r <= lat_nxt;
      burst_data_valid <= bdv_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      bpart_r <= 2'h0;
      pe_start <= 1'b0;
      pe_is_erase <= 1'b0;
      pe_addr <= '0;
      pe_data <= '0;
      pe_abort <= 1'b0;
    end else begin
      busy_r <= rst_s & (go | (busy_r & ~pe_done));
      bpart_r <= go ? wp : bpart_r;
      pe_start <= go & rst_s;
      pe_is_erase <= go ? go_erase : pe_is_erase;
      pe_addr <= go ? wa_r : pe_addr;
      pe_data <= go ? wd_r : pe_data;
      pe_abort <= busy_r & ~rst_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
    end else begin
      array_addr <= rd_addr;
      dq_out <= dq_nxt;
      dq_oe <= rd_cycle;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_DQ_GATE: assert property (
    $rose(dq_oe) |-> $past(!p_s_r.oe_n && p_s_r.we_n))
    else $error("data driven without output gate");
  AST_DESELECT: assert property (
    p_s_r.ce_n |=> !dq_oe)
    else $error("data driven while deselected");
  AST_INIT_STOP: assert property (
    !rst_s |=> !busy_r && !pe_start)
    else $error("automation alive under init");
  AST_ASYNC_READ: assert property (
    !rst_s |=> rcr_r[fbp_pkg::RCR_ASYNC] && mode_r == 4'h0)
    else $error("not in asynchronous array read after init");
  AST_ADDR_HOLD: assert property (
    p_s_r.adv_n |=> $stable(addr_r))
    else $error("address moved with strobe high");
  AST_VPP_REFUSE: assert property (
    pe_start |-> $past(!p_s_r.vpp_low))
    else $error("operation started at low program voltage");
  AST_SINGLE_OP: assert property (
    pe_start |-> !$past(busy_r))
    else $error("second operation started while busy");
  AST_LOCKED_REFUSE: assert property (
    pe_start |-> !lock_r[block_of(pe_addr)])
    else $error("operation started on locked block");
  AST_LOCKDOWN: assert property (
    rst_s && !p_s_r.wp_n |=> (ldn_r & $past(lock_r) & ~lock_r) == '0)
    else $error("locked-down block unlocked with guard low");
  AST_BURST_WAIT: assert property (
    bst_cap && lat_val != 3'h0 && !p_s_r.oe_n && !p_s_r.ce_n
      ##1 !p_s_r.oe_n && !p_s_r.ce_n |=> !burst_data_valid)
    else $error("valid flag high during burst latency");
endmodule

// >>> test/fbp_host_model.sv
// Purpose: memory controller model on the flash pins
// Assumes: each pin level stands at least four pclk cycles
// Notes: released address and data lines show the inverse value
`timescale 1ns/100ps
module fbp_host_model (
  // clock
  input wire logic pclk,
  // flash pins
  output logic flash_clk,
  output logic address_latch_strobe_n,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic hard_init_n,
  output logic lockdown_guard_n,
  output logic vpp_at_lockout,
  output logic [20:0] addr_pin,
  output logic [15:0] dq_in
);
  initial begin
    flash_clk = 1'b0;
    address_latch_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    output_gate_n = 1'b1;
    hard_init_n = 1'b0;
    lockdown_guard_n = 1'b1;
    vpp_at_lockout = 1'b0;
    addr_pin = 21'h0;
    dq_in = 16'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // scrambled after the strobe rise so a missing hold shows
  task automatic put_addr(input logic [20:0] a);
    addr_pin <= a;
    address_latch_strobe_n <= 1'b0;
    hold(4);
    address_latch_strobe_n <= 1'b1;
    hold(4);
    addr_pin <= ~a;
  endtask
  // data flips at the write rise while select stays low
  task automatic wr_cmd(input logic [20:0] a, input logic [15:0] d);
    put_addr(a);
    dq_in <= d;
    chip_select_n <= 1'b0;
    write_strobe_n <= 1'b0;
    hold(4);
    write_strobe_n <= 1'b1;
    dq_in <= ~d;
    hold(4);
    chip_select_n <= 1'b1;
    hold(4);
  endtask
  task automatic open_read(input logic [20:0] a);
    put_addr(a);
    chip_select_n <= 1'b0;
    output_gate_n <= 1'b0;
    hold(8);
  endtask
  task automatic close_read();
    chip_select_n <= 1'b1;
    output_gate_n <= 1'b1;
    hold(6);
  endtask
  // burst: address taken on the first clock rise with strobe low
  task automatic burst_open(input logic [20:0] a);
    addr_pin <= a;
    address_latch_strobe_n <= 1'b0;
    chip_select_n <= 1'b0;
    output_gate_n <= 1'b0;
    hold(4);
    flash_clk <= 1'b1;
    hold(4);
    address_latch_strobe_n <= 1'b1;
    flash_clk <= 1'b0;
    hold(4);
    addr_pin <= ~a;
  endtask
  // clock stands still between pulses, as outside a burst
  task automatic clk_pulse();
    flash_clk <= 1'b1;
    hold(4);
    flash_clk <= 1'b0;
    hold(4);
  endtask
  task automatic set_pins(input logic ini, input logic grd,
                          input logic vlo);
    hard_init_n <= ini;
    lockdown_guard_n <= grd;
    vpp_at_lockout <= vlo;
    hold(6);
  endtask
endmodule

// >>> test/testbench.sv
// Purpose: self-checking bench of the flash bus port
// Assumes: array word is its address folded with a fixed mask
// Notes: one rising-edge burst, no-wrap, flash_clk idles low
`timescale 1ns/100ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic fclk, address_latch_strobe_n, cs_n, we_n, oe_n, ini_n, grd_n, vlo;
  logic [20:0] addr_pin, array_addr, pe_addr;
  logic [15:0] dq_in, dq_out, pe_data, array_rdata;
  logic dq_oe, burst_data_valid, pe_start, pe_is_erase, pe_abort;
  logic pe_done = 1'b0;
  logic [3:0] busy_cnt = 4'h0, pe_len = 4'h5;
  int mismatches = 0, checks_done = 0, starts = 0, aborts = 0;
  assign array_rdata = array_addr[15:0] ^ 16'h5A5A;
  fbp_host_model host (.pclk(pclk), .flash_clk(fclk), .chip_select_n(cs_n),
    .address_latch_strobe_n(address_latch_strobe_n), .write_strobe_n(we_n),
    .output_gate_n(oe_n), .hard_init_n(ini_n), .lockdown_guard_n(grd_n),
    .vpp_at_lockout(vlo), .addr_pin(addr_pin), .dq_in(dq_in));
  fbp_flash_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_clk(fclk),
    .address_latch_strobe_n(address_latch_strobe_n), .chip_select_n(cs_n),
    .write_strobe_n(we_n), .output_gate_n(oe_n), .hard_init_n(ini_n),
    .lockdown_guard_n(grd_n), .vpp_at_lockout(vlo), .addr_pin(addr_pin),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .burst_data_valid(burst_data_valid), .array_addr(array_addr),
    .array_rdata(array_rdata), .pe_start(pe_start),
    .pe_is_erase(pe_is_erase), .pe_addr(pe_addr), .pe_data(pe_data),
    .pe_abort(pe_abort), .pe_done(pe_done));
  // ---------------------------------------------------------------
  // engine model: finishes pe_len cycles after each start
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    pe_done <= (busy_cnt == 4'h1);
    busy_cnt <= (pe_start === 1'b1) ? pe_len : busy_cnt - (busy_cnt != 4'h0);
    if (pe_start === 1'b1) starts <= starts + 1;
    if (pe_abort === 1'b1) aborts <= aborts + 1;
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // clear status, two-cycle command, then count engine starts
  task automatic op(input logic [7:0] c, input logic [20:0] a,
                    input logic [15:0] d, input int exp);
    int s0, n;
    s0 = starts;
    host.wr_cmd(a, {8'h00, fbp_pkg::CMD_CLEAR_STATUS});
    host.wr_cmd(a, {8'h00, c});
    host.wr_cmd(a, d);
    for (n = 0; n < 30 && starts == s0; n++) @(posedge pclk);
    chk(starts - s0, exp);
    if (exp == 1) chk(pe_addr, a);
    if (exp == 1) chk(pe_is_erase, c == fbp_pkg::CMD_ERASE);
    if (exp == 1 && c == fbp_pkg::CMD_PROGRAM) chk(pe_data, d);
  endtask
  task automatic sc_reset();
    apb(1'b0, fbp_pkg::REG_RCR, 32'h0);
    chk(rd, fbp_pkg::RCR_RESET);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[0], err}, 2'b01);
    apb(1'b1, fbp_pkg::REG_PART, 32'h5);
    apb(1'b0, fbp_pkg::REG_PART, 32'h0);
    chk(rd, 32'h5);
  endtask
  task automatic sc_read();
    chk(dq_oe, 1'b0);
    host.open_read(21'h001234);
    #1 chk({dq_oe, dq_out}, {1'b1, 16'h1234 ^ 16'h5A5A});
    @(posedge pclk);
    host.close_read();
    #1 chk(dq_oe, 1'b0);
    @(posedge pclk);
  endtask
  task automatic sc_locks();
    op(fbp_pkg::CMD_PROGRAM, 21'h008003, 16'h1234, 0);
    op(fbp_pkg::CMD_LOCK_SETUP, 21'h008000, 16'h00D0, 0);
    op(fbp_pkg::CMD_PROGRAM, 21'h008003, 16'h1234, 1);
    op(fbp_pkg::CMD_ERASE, 21'h008000, 16'h00D0, 1);
  endtask
  task automatic sc_guard();
    op(fbp_pkg::CMD_LOCK_SETUP, 21'h010000, 16'h002F, 0);
    host.set_pins(1'b1, 1'b0, 1'b0);
    op(fbp_pkg::CMD_LOCK_SETUP, 21'h010000, 16'h00D0, 0);
    op(fbp_pkg::CMD_PROGRAM, 21'h010001, 16'h55AA, 0);
    op(fbp_pkg::CMD_PROGRAM, 21'h008001, 16'hAA55, 1);
    host.set_pins(1'b1, 1'b1, 1'b0);
    op(fbp_pkg::CMD_LOCK_SETUP, 21'h010000, 16'h00D0, 0);
    op(fbp_pkg::CMD_PROGRAM, 21'h010001, 16'h55AA, 1);
  endtask
  task automatic sc_vpp_init();
    host.set_pins(1'b1, 1'b1, 1'b1);
    op(fbp_pkg::CMD_PROGRAM, 21'h008002, 16'h0F0F, 0);
    op(fbp_pkg::CMD_ERASE, 21'h008000, 16'h00D0, 0);
    host.set_pins(1'b1, 1'b1, 1'b0);
    apb(1'b1, fbp_pkg::REG_RCR, 32'h1234);
    pe_len <= 4'hF;
    op(fbp_pkg::CMD_PROGRAM, 21'h008004, 16'h0F0F, 1);
    host.set_pins(1'b0, 1'b1, 1'b0);
    chk(aborts, 1);
    op(fbp_pkg::CMD_PROGRAM, 21'h008002, 16'h0F0F, 0);
    host.set_pins(1'b1, 1'b1, 1'b0);
    apb(1'b0, fbp_pkg::REG_RCR, 32'h0);
    chk(rd, fbp_pkg::RCR_RESET);
    op(fbp_pkg::CMD_PROGRAM, 21'h008002, 16'h0F0F, 0);
  endtask
  // latency two rising edges, 4-word length with no-wrap
  task automatic sc_burst();
    apb(1'b1, fbp_pkg::REG_RCR, 32'h1049);
    host.burst_open(21'h000103);
    #1 chk({burst_data_valid, array_addr}, 22'h000103);
    @(posedge pclk);
    repeat (3) host.clk_pulse();
    #1 chk({burst_data_valid, array_addr}, 22'h200104);
    @(posedge pclk);
    host.close_read();
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    host.set_pins(1'b1, 1'b1, 1'b0);
    sc_reset();
    sc_read();
    sc_locks();
    sc_guard();
    sc_vpp_init();
    sc_burst();
    report_and_stop();
  end
endmodule
